// ===== flag_source_model.sv
// Peripheral flag sources that stand in front of the interrupt gating block.
`timescale 1ns/1ps
module flag_source_model (
  input wire logic clock, // Core clock
  output logic ext0Flag, // External request zero
  output logic timer0Flag, // Timer 0 overflow
  output logic ext1Flag, // External request one
  output logic timer1Flag, // Timer 1 overflow
  output logic uart0RxFlag, // Uart 0 receive
  output logic uart0TxFlag, // Uart 0 transmit
  output logic timer2Flag, // Timer 2 overflow
  output logic spiFlag, // Spi request
  output logic i2cFlag, // I2c request
  output logic adcFlag, // Conversion done
  output logic counterArrayFlag, // Counter array request
  output logic uart1RxFlag, // Uart 1 receive
  output logic uart1TxFlag // Uart 1 transmit
);
  initial
  begin
    {ext0Flag, timer0Flag, ext1Flag, timer1Flag, uart0RxFlag, uart0TxFlag, timer2Flag} = '0;
    {spiFlag, i2cFlag, adcFlag, counterArrayFlag, uart1RxFlag, uart1TxFlag} = '0;
  end

  // ----------------------------------------------------------------
  // Flag stimulus
  // ----------------------------------------------------------------
  // Flags change only after a falling edge so the block samples settled levels.
  // A uart request is raised through one of its two flags, chosen by useTx.
  task automatic set_flags(input logic [10:0] src, input logic useTx);
    @(negedge clock);
    ext0Flag = src[0];
    timer0Flag = src[1];
    ext1Flag = src[2];
    timer1Flag = src[3];
    uart0RxFlag = src[4] & ~useTx;
    uart0TxFlag = src[4] & useTx;
    timer2Flag = src[5];
    spiFlag = src[6];
    i2cFlag = src[7];
    adcFlag = src[8];
    counterArrayFlag = src[9];
    uart1RxFlag = src[10] & ~useTx;
    uart1TxFlag = src[10] & useTx;
  endtask
endmodule

// ===== irq_enable_priority_regs.sv
// Interrupt enable and priority special-function registers with request gating.
`timescale 1ns/1ps

// Summary of operation
// - Global gate at 0 blocks every request, whatever the enables hold.
// - Global gate at 1 passes a request only if its own enable is set.
// - Main enable bit 6 is stored read/write for the debugger trace function.
// - Enable bit 1 lets the source interrupt; 0 suppresses it.
// - Main enable holds timer2, uart0, timer1, ext1, timer0, ext0 at bits 5..0.
// - Priority bit 1 means high level, 0 means low level.
// - Main priority holds the six main sources at bits 5..0; 7 and 6 reserved.
// - Extra enable sits at A7h and resets to 00h.
// - Main priority sits at B8h and resets to 00h.
// - Extra priority sits at B7h and resets to 00h.
// - Main enable sits at A8h and resets to 00h, all interrupts off.
// - Each uart request is the OR of its receive and transmit flags.
module irq_enable_priority_regs
  import irq_regs_pkg::*;
(
  input wire logic clock, // Core clock
  input wire logic reset_n, // Asynchronous reset, active low
  input wire logic [7:0] sfrAddr, // Special-function address
  input wire logic sfrWrite, // Write strobe, one cycle
  input wire logic sfrRead, // Read strobe, one cycle
  input wire logic [7:0] sfrWriteData, // Write data
  output logic [7:0] sfrReadData, // Read data, valid the cycle after the strobe
  output logic sfrSelected, // Access targets one of these registers
  input wire logic ext0Flag, // External request zero pending
  input wire logic timer0Flag, // Timer 0 overflow pending
  input wire logic ext1Flag, // External request one pending
  input wire logic timer1Flag, // Timer 1 overflow pending
  input wire logic uart0RxFlag, // Uart 0 byte received
  input wire logic uart0TxFlag, // Uart 0 byte transmitted
  input wire logic timer2Flag, // Timer 2 overflow or capture pending
  input wire logic spiFlag, // Spi request pending
  input wire logic i2cFlag, // I2c request pending
  input wire logic adcFlag, // Conversion complete
  input wire logic counterArrayFlag, // Counter array request pending
  input wire logic uart1RxFlag, // Uart 1 byte received
  input wire logic uart1TxFlag, // Uart 1 byte transmitted
  output logic [SRC_COUNT-1:0] irqRequest, // Gated requests, polling order
  output logic [SRC_COUNT-1:0] irqHighPrio, // Gated requests at high level
  output logic irqAnyHigh, // Some high-level request pending
  output logic irqAnyLow, // Some low-level request pending
  output logic debugTraceBit // Trace bit held for the debugger
);

  // ----------------------------------------------------------------
  // Register state
  // ----------------------------------------------------------------
  logic [7:0] irqEnableMain_reg;
  logic [7:0] irqEnableMain_next;
  logic [7:0] irqEnableExtra_reg;
  logic [7:0] irqEnableExtra_next;
  logic [7:0] irqPriorityMain_reg;
  logic [7:0] irqPriorityMain_next;
  logic [7:0] irqPriorityExtra_reg;
  logic [7:0] irqPriorityExtra_next;
  logic [7:0] sfrReadData_reg;
  logic [7:0] sfrReadData_next;
  logic [7:0] readMux;
  logic addrMapped;

  logic [SRC_COUNT-1:0] irqRequest_reg;
  logic [SRC_COUNT-1:0] irqRequest_next;
  logic [SRC_COUNT-1:0] irqHighPrio_reg;
  logic [SRC_COUNT-1:0] irqHighPrio_next;
  logic irqAnyHigh_reg;
  logic irqAnyHigh_next;
  logic irqAnyLow_reg;
  logic irqAnyLow_next;

  logic [SRC_COUNT-1:0] srcFlagVec;
  logic [SRC_COUNT-1:0] srcEnableVec;
  logic [SRC_COUNT-1:0] srcPrioVec;

  irq_gate_if #(.N(SRC_COUNT)) gateBus ();

  // ----------------------------------------------------------------
  // Address decode and read path
  // ----------------------------------------------------------------
  always_comb
  begin
    addrMapped = 1'b1;
    case (sfrAddr)
      ADDR_ENABLE_MAIN: readMux = irqEnableMain_reg;
      ADDR_ENABLE_EXTRA: readMux = irqEnableExtra_reg & ENABLE_EXTRA_MASK;
      ADDR_PRIO_MAIN: readMux = irqPriorityMain_reg & PRIO_MAIN_MASK;
      ADDR_PRIO_EXTRA: readMux = irqPriorityExtra_reg & PRIO_EXTRA_MASK;
      default:
      begin
        readMux = READ_IDLE_VALUE;
        addrMapped = 1'b0;
      end
    endcase
  end

  assign sfrSelected = addrMapped & (sfrRead | sfrWrite);

  // ----------------------------------------------------------------
  // Register writes
  // ----------------------------------------------------------------
  // Reserved bits are masked off on write, so a stray 1 there cannot
  // later leak into gating or read-back.
  always_comb
  begin
    irqEnableMain_next = irqEnableMain_reg;
    irqEnableExtra_next = irqEnableExtra_reg;
    irqPriorityMain_next = irqPriorityMain_reg;
    irqPriorityExtra_next = irqPriorityExtra_reg;
    sfrReadData_next = sfrReadData_reg;
    if (sfrWrite)
    begin
      case (sfrAddr)
        ADDR_ENABLE_MAIN: irqEnableMain_next = sfrWriteData & ENABLE_MAIN_MASK;
        ADDR_ENABLE_EXTRA: irqEnableExtra_next = sfrWriteData & ENABLE_EXTRA_MASK;
        ADDR_PRIO_MAIN: irqPriorityMain_next = sfrWriteData & PRIO_MAIN_MASK;
        ADDR_PRIO_EXTRA: irqPriorityExtra_next = sfrWriteData & PRIO_EXTRA_MASK;
        default: irqEnableMain_next = irqEnableMain_reg;
      endcase
    end
    if (sfrRead)
    begin
      sfrReadData_next = readMux;
    end
  end

  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
    begin
      irqEnableMain_reg <= RESET_ENABLE_MAIN;
      irqEnableExtra_reg <= RESET_ENABLE_EXTRA;
      irqPriorityMain_reg <= RESET_PRIO_MAIN;
      irqPriorityExtra_reg <= RESET_PRIO_EXTRA;
      sfrReadData_reg <= READ_IDLE_VALUE;
    end
    else
    begin
      irqEnableMain_reg <= irqEnableMain_next;
      irqEnableExtra_reg <= irqEnableExtra_next;
      irqPriorityMain_reg <= irqPriorityMain_next;
      irqPriorityExtra_reg <= irqPriorityExtra_next;
      sfrReadData_reg <= sfrReadData_next;
    end
  end

  assign sfrReadData = sfrReadData_reg;
  assign debugTraceBit = irqEnableMain_reg[BIT_TRACE];

  // ----------------------------------------------------------------
  // Source vectors and gating
  // ----------------------------------------------------------------
  // Flags come from peripheral logic on this clock, so no synchroniser.
  always_comb
  begin
    srcFlagVec = '0;
    srcFlagVec[SRC_EXT0] = ext0Flag;
    srcFlagVec[SRC_TIMER0] = timer0Flag;
    srcFlagVec[SRC_EXT1] = ext1Flag;
    srcFlagVec[SRC_TIMER1] = timer1Flag;
    srcFlagVec[SRC_UART0] = uart0RxFlag | uart0TxFlag;
    srcFlagVec[SRC_TIMER2] = timer2Flag;
    srcFlagVec[SRC_SPI] = spiFlag;
    srcFlagVec[SRC_I2C] = i2cFlag;
    srcFlagVec[SRC_ADC] = adcFlag;
    srcFlagVec[SRC_COUNTER_ARRAY] = counterArrayFlag;
    srcFlagVec[SRC_UART1] = uart1RxFlag | uart1TxFlag;
  end

  assign srcEnableVec = gather_sources(irqEnableMain_reg, irqEnableExtra_reg);
  assign srcPrioVec = gather_sources(irqPriorityMain_reg, irqPriorityExtra_reg);

  assign gateBus.globalIrqGate = irqEnableMain_reg[BIT_GLOBAL_GATE];
  assign gateBus.sourceEnable = srcEnableVec;
  assign gateBus.sourcePrio = srcPrioVec;
  assign gateBus.sourceFlag = srcFlagVec;

  irq_gate_unit gateUnit (
    .gateBus(gateBus)
  );

  // ----------------------------------------------------------------
  // Registered request outputs
  // ----------------------------------------------------------------
  // One cycle of latency is traded for glitch-free outputs to the sequencer.
  always_comb
  begin
    irqRequest_next = gateBus.gatedRequest;
    irqHighPrio_next = gateBus.gatedHighPrio;
    irqAnyHigh_next = |gateBus.gatedHighPrio;
    irqAnyLow_next = |(gateBus.gatedRequest & ~gateBus.gatedHighPrio);
  end

  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
    begin
      irqRequest_reg <= '0;
      irqHighPrio_reg <= '0;
      irqAnyHigh_reg <= 1'b0;
      irqAnyLow_reg <= 1'b0;
    end
    else
    begin
      irqRequest_reg <= irqRequest_next;
      irqHighPrio_reg <= irqHighPrio_next;
      irqAnyHigh_reg <= irqAnyHigh_next;
      irqAnyLow_reg <= irqAnyLow_next;
    end
  end

  assign irqRequest = irqRequest_reg;
  assign irqHighPrio = irqHighPrio_reg;
  assign irqAnyHigh = irqAnyHigh_reg;
  assign irqAnyLow = irqAnyLow_reg;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  gate_off_a:
    assert property (@(posedge clock) disable iff (!reset_n)
      !irqEnableMain_reg[BIT_GLOBAL_GATE] |=> (irqRequest == '0) && !irqAnyHigh && !irqAnyLow)
    else $error("Request passed while the global gate was off");

  gate_pass_a:
    assert property (@(posedge clock) disable iff (!reset_n)
      irqEnableMain_reg[BIT_GLOBAL_GATE] |=>
        irqRequest == ($past(srcEnableVec) & $past(srcFlagVec)))
    else $error("Gated request does not follow enable and flag");

  trace_bit_a:
    assert property (@(posedge clock) disable iff (!reset_n)
      (sfrWrite && sfrAddr == ADDR_ENABLE_MAIN) ##1 !sfrWrite |->
        debugTraceBit == $past(sfrWriteData[BIT_TRACE]))
    else $error("Trace bit not kept as written");

  main_enable_a:
    assert property (@(posedge clock) disable iff (!reset_n)
      sfrWrite && sfrAddr == ADDR_ENABLE_MAIN |=> irqEnableMain_reg == $past(sfrWriteData))
    else $error("Main enable register did not take the write");

  extra_enable_a:
    assert property (@(posedge clock) disable iff (!reset_n)
      sfrWrite && sfrAddr == ADDR_ENABLE_EXTRA |=>
        irqEnableExtra_reg == ($past(sfrWriteData) & ENABLE_EXTRA_MASK))
    else $error("Extra enable register wrong after write");

  single_enable_a:
    assert property (@(posedge clock) disable iff (!reset_n)
      irqEnableMain_reg[BIT_GLOBAL_GATE] && adcFlag && !irqEnableExtra_reg[BIT_ADC]
        |=> !irqRequest[SRC_ADC])
    else $error("Disabled source raised a request");

  main_prio_a:
    assert property (@(posedge clock) disable iff (!reset_n)
      sfrWrite && sfrAddr == ADDR_PRIO_MAIN |=>
        irqPriorityMain_reg == ($past(sfrWriteData) & PRIO_MAIN_MASK))
    else $error("Main priority register wrong after write");

  extra_prio_a:
    assert property (@(posedge clock) disable iff (!reset_n)
      sfrWrite && sfrAddr == ADDR_PRIO_EXTRA |=>
        irqPriorityExtra_reg == ($past(sfrWriteData) & PRIO_EXTRA_MASK))
    else $error("Extra priority register wrong after write");

  reset_state_a:
    assert property (@(posedge clock)
      $rose(reset_n) |-> irqEnableMain_reg == RESET_ENABLE_MAIN
        && irqEnableExtra_reg == RESET_ENABLE_EXTRA
        && irqPriorityMain_reg == RESET_PRIO_MAIN
        && irqPriorityExtra_reg == RESET_PRIO_EXTRA)
    else $error("Registers not cleared by reset");

  reset_gate_a:
    assert property (@(posedge clock)
      $rose(reset_n) |-> irqRequest == '0 ##1 irqRequest == '0)
    else $error("Request seen right after reset");

  prio_readback_a:
    assert property (@(posedge clock) disable iff (!reset_n)
      sfrRead && sfrAddr == ADDR_PRIO_MAIN && !sfrWrite |=>
        sfrReadData == ($past(irqPriorityMain_reg) & PRIO_MAIN_MASK))
    else $error("Main priority read-back wrong");

  extra_readback_a:
    assert property (@(posedge clock) disable iff (!reset_n)
      sfrRead && sfrAddr == ADDR_PRIO_EXTRA |=> (sfrReadData & ~PRIO_EXTRA_MASK) == 8'h00)
    else $error("Reserved priority bits read as one");

  uart_or_a:
    assert property (@(posedge clock) disable iff (!reset_n)
      irqEnableMain_reg[BIT_GLOBAL_GATE] && irqEnableMain_reg[BIT_UART0]
        && (uart0RxFlag || uart0TxFlag) |=> irqRequest[SRC_UART0])
    else $error("Uart 0 flag did not raise its request");

  reserved_gate_a:
    assert property (@(posedge clock) disable iff (!reset_n)
      (irqEnableExtra_reg & ~ENABLE_EXTRA_MASK) == 8'h00
        && (irqPriorityMain_reg & ~PRIO_MAIN_MASK) == 8'h00)
    else $error("Reserved bit stored as one");

  prio_tag_a:
    assert property (@(posedge clock) disable iff (!reset_n)
      1'b1 |=> irqHighPrio == (irqRequest & $past(srcPrioVec))
        && irqAnyLow == |(irqRequest & ~irqHighPrio))
    else $error("Priority tag does not match the request");

  level_split_a:
    assert property (@(posedge clock) disable iff (!reset_n)
      irqAnyHigh |-> (irqHighPrio & ~irqRequest) == '0 && irqHighPrio != '0)
    else $error("High-level flag without a high request");

endmodule

// ===== irq_enable_priority_regs_tb.sv
// Self-checking testbench for the interrupt enable and priority registers.
`timescale 1ns/1ps
module irq_enable_priority_regs_tb;
  import irq_regs_pkg::*;
  logic clock, reset_n, sfrWrite, sfrRead, sfrSelected;
  logic [7:0] sfrAddr, sfrWriteData, sfrReadData;
  logic ext0Flag, timer0Flag, ext1Flag, timer1Flag, uart0RxFlag, uart0TxFlag, timer2Flag;
  logic spiFlag, i2cFlag, adcFlag, counterArrayFlag, uart1RxFlag, uart1TxFlag;
  logic [10:0] irqRequest, irqHighPrio;
  logic irqAnyHigh, irqAnyLow, debugTraceBit;
  int errors = 0;
  int total_checks = 0;
  int cycles = 0;
  int inMain[11] = '{1, 1, 1, 1, 1, 1, 0, 0, 0, 0, 0};
  int bitPos[11] = '{0, 1, 2, 3, 4, 5, 6, 1, 7, 5, 4};

  irq_enable_priority_regs dut (.clock(clock), .reset_n(reset_n), .sfrAddr(sfrAddr),
    .sfrWrite(sfrWrite), .sfrRead(sfrRead), .sfrWriteData(sfrWriteData),
    .sfrReadData(sfrReadData), .sfrSelected(sfrSelected), .ext0Flag(ext0Flag),
    .timer0Flag(timer0Flag), .ext1Flag(ext1Flag), .timer1Flag(timer1Flag),
    .uart0RxFlag(uart0RxFlag), .uart0TxFlag(uart0TxFlag), .timer2Flag(timer2Flag),
    .spiFlag(spiFlag), .i2cFlag(i2cFlag), .adcFlag(adcFlag),
    .counterArrayFlag(counterArrayFlag), .uart1RxFlag(uart1RxFlag),
    .uart1TxFlag(uart1TxFlag), .irqRequest(irqRequest), .irqHighPrio(irqHighPrio),
    .irqAnyHigh(irqAnyHigh), .irqAnyLow(irqAnyLow), .debugTraceBit(debugTraceBit));

  flag_source_model partner (.clock(clock), .ext0Flag(ext0Flag), .timer0Flag(timer0Flag),
    .ext1Flag(ext1Flag), .timer1Flag(timer1Flag), .uart0RxFlag(uart0RxFlag),
    .uart0TxFlag(uart0TxFlag), .timer2Flag(timer2Flag), .spiFlag(spiFlag),
    .i2cFlag(i2cFlag), .adcFlag(adcFlag), .counterArrayFlag(counterArrayFlag),
    .uart1RxFlag(uart1RxFlag), .uart1TxFlag(uart1TxFlag));

  // ----------------------------------------------------------------
  // Clock, timeout and shared tasks
  // ----------------------------------------------------------------
  initial
  begin
    clock = 1'b0;
    forever #50 clock = ~clock;
  end

  // The whole run needs under 200 cycles; the ceiling leaves wide margin.
  always @(posedge clock)
  begin
    cycles <= cycles + 1;
    if (cycles == 3000)
    begin
      errors = errors + 1;
      wrap_up();
    end
  end

  task automatic wrap_up();
    $display("checks %0d, mismatches %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    total_checks = total_checks + 1;
    if (seen !== exp)
    begin
      errors = errors + 1;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic sfr_write(input logic [7:0] addr, input logic [7:0] data);
    @(negedge clock);
    sfrAddr = addr;
    sfrWriteData = data;
    sfrWrite = 1'b1;
    @(negedge clock);
    sfrWrite = 1'b0;
  endtask

  // Strobe held one cycle; the data is loaded at that edge and read after it.
  task automatic sfr_read(input logic [7:0] addr, output logic [7:0] data);
    logic sel;
    sel = (addr == 8'hA7) || (addr == 8'hA8) || (addr == 8'hB7) || (addr == 8'hB8);
    @(negedge clock);
    sfrAddr = addr;
    sfrRead = 1'b1;
    #1;
    check(sfrSelected, sel);
    @(negedge clock);
    sfrRead = 1'b0;
    data = sfrReadData;
  endtask

  task automatic read_check(input logic [7:0] addr, input logic [7:0] exp);
    logic [7:0] got;
    sfr_read(addr, got);
    check(got, exp);
  endtask

  // Software path: bit 6 of the main enable register is read back and kept.
  task automatic write_main(input logic [7:0] data);
    logic [7:0] cur;
    sfr_read(8'hA8, cur);
    sfr_write(8'hA8, {data[7], cur[6], data[5:0]});
  endtask

  task automatic check_outputs(input logic [10:0] req, input logic [10:0] hi);
    check(irqRequest, req);
    check(irqHighPrio, hi);
    check(irqAnyHigh, |hi);
    check(irqAnyLow, |(req & ~hi));
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial
  begin
    reset_n = 1'b0;
    sfrAddr = 8'h00;
    sfrWrite = 1'b0;
    sfrRead = 1'b0;
    sfrWriteData = 8'h00;
    repeat (12) @(negedge clock);
    reset_n = 1'b1;
    read_check(8'hA7, 8'h00);
    read_check(8'hB8, 8'h00);
    read_check(8'hB7, 8'h00);
    read_check(8'hA8, 8'h00);
    partner.set_flags(11'h7FF, 1'b0);
    @(negedge clock);
    check_outputs(11'h000, 11'h000);
    // Reserved priority bits are dropped; the extra enable never sees 1 on reserved bits.
    sfr_write(8'hB8, 8'hFF);
    read_check(8'hB8, 8'h3F);
    sfr_write(8'hB7, 8'hFF);
    read_check(8'hB7, 8'hF2);
    sfr_write(8'hA7, 8'hF2);
    read_check(8'hA7, 8'hF2);
    sfr_write(8'h55, 8'hFF);
    read_check(8'h55, 8'h00);
    sfr_write(8'hB8, 8'h00);
    sfr_write(8'hB7, 8'h00);
    // One source enabled at a time, with every source raised, each uart through one of its two flags.
    for (int i = 0; i < 11; i++)
    begin
      partner.set_flags(11'h7FF, i[1]);
      write_main(8'h80 | (inMain[i] ? (8'h01 << bitPos[i]) : 8'h00));
      sfr_write(8'hA7, inMain[i] ? 8'h00 : (8'h01 << bitPos[i]));
      @(negedge clock);
      check_outputs(11'h001 << i, 11'h000);
    end
    // Gate closed with every enable set blocks all requests.
    write_main(8'h3F);
    sfr_write(8'hA7, 8'hF2);
    @(negedge clock);
    check_outputs(11'h000, 11'h000);
    // Gate open: mixed priority levels.
    write_main(8'hBF);
    sfr_write(8'hB8, 8'h15);
    sfr_write(8'hB7, 8'h50);
    @(negedge clock);
    check_outputs(11'h7FF, 11'h455);
    partner.set_flags(11'h455, 1'b1);
    @(negedge clock);
    check_outputs(11'h455, 11'h455);
    partner.set_flags(11'h000, 1'b0);
    @(negedge clock);
    check_outputs(11'h000, 11'h000);
    // Debugger sets the trace bit; a later software write keeps it.
    sfr_write(8'hA8, 8'h40);
    read_check(8'hA8, 8'h40);
    check(debugTraceBit, 1'b1);
    write_main(8'h80);
    read_check(8'hA8, 8'hC0);
    // A reset in mid-run clears the trace bit and closes the gate again.
    @(negedge clock);
    reset_n = 1'b0;
    @(negedge clock);
    reset_n = 1'b1;
    read_check(8'hA8, 8'h00);
    check(debugTraceBit, 1'b0);
    wrap_up();
  end
endmodule

// ===== irq_gate_if.sv
// Signals between the interrupt register file and its gating unit.
`timescale 1ns/1ps
interface irq_gate_if #(parameter int N = 11);
  logic globalIrqGate;
  logic [N-1:0] sourceEnable;
  logic [N-1:0] sourcePrio;
  logic [N-1:0] sourceFlag;
  logic [N-1:0] gatedRequest;
  logic [N-1:0] gatedHighPrio;

  modport regs (
    output globalIrqGate,
    output sourceEnable,
    output sourcePrio,
    output sourceFlag,
    input gatedRequest,
    input gatedHighPrio
  );

  modport gate (
    input globalIrqGate,
    input sourceEnable,
    input sourcePrio,
    input sourceFlag,
    output gatedRequest,
    output gatedHighPrio
  );
endinterface

// ===== irq_gate_unit.sv
// Combinational gating of source flags by the global gate and per-source enables.
`timescale 1ns/1ps
module irq_gate_unit (
  irq_gate_if.gate gateBus // Register values in, gated requests out
);

  // ----------------------------------------------------------------
  // Gating
  // ----------------------------------------------------------------
  // The global gate overrides every individual enable.
  always_comb
  begin
    if (gateBus.globalIrqGate)
    begin
      gateBus.gatedRequest = gateBus.sourceEnable & gateBus.sourceFlag;
    end
    else
    begin
      gateBus.gatedRequest = '0;
    end
    gateBus.gatedHighPrio = gateBus.gatedRequest & gateBus.sourcePrio;
  end

endmodule

// ===== irq_regs_pkg.sv
// Constants, source indices and field helpers for the interrupt enable and priority registers.
package irq_regs_pkg;

  // ----------------------------------------------------------------
  // Sizes and special-function addresses
  // ----------------------------------------------------------------
  localparam int SRC_COUNT = 11;
  localparam int SFR_WIDTH = 8;
  localparam logic [7:0] ADDR_ENABLE_EXTRA = 8'hA7;
  localparam logic [7:0] ADDR_ENABLE_MAIN = 8'hA8;
  localparam logic [7:0] ADDR_PRIO_EXTRA = 8'hB7;
  localparam logic [7:0] ADDR_PRIO_MAIN = 8'hB8;

  // ----------------------------------------------------------------
  // Reset values and implemented-bit masks
  // ----------------------------------------------------------------
  localparam logic [7:0] RESET_ENABLE_MAIN = 8'h00;
  localparam logic [7:0] RESET_ENABLE_EXTRA = 8'h00;
  localparam logic [7:0] RESET_PRIO_MAIN = 8'h00;
  localparam logic [7:0] RESET_PRIO_EXTRA = 8'h00;
  localparam logic [7:0] ENABLE_MAIN_MASK = 8'hFF;
  localparam logic [7:0] ENABLE_EXTRA_MASK = 8'hF2;
  localparam logic [7:0] PRIO_MAIN_MASK = 8'h3F;
  localparam logic [7:0] PRIO_EXTRA_MASK = 8'hF2;
  localparam logic [7:0] READ_IDLE_VALUE = 8'h00;

  // ----------------------------------------------------------------
  // Field positions; the source bits are shared by the enable and the priority registers
  // ----------------------------------------------------------------
  localparam int BIT_GLOBAL_GATE = 7;
  localparam int BIT_TRACE = 6;
  localparam int BIT_TIMER2 = 5;
  localparam int BIT_UART0 = 4;
  localparam int BIT_TIMER1 = 3;
  localparam int BIT_EXT1 = 2;
  localparam int BIT_TIMER0 = 1;
  localparam int BIT_EXT0 = 0;
  localparam int BIT_ADC = 7;
  localparam int BIT_SPI = 6;
  localparam int BIT_COUNTER_ARRAY = 5;
  localparam int BIT_UART1 = 4;
  localparam int BIT_I2C = 1;

  // Source index in the request vectors, in polling order.
  typedef enum logic [3:0] {
    SRC_EXT0 = 4'h0,
    SRC_TIMER0 = 4'h1,
    SRC_EXT1 = 4'h2,
    SRC_TIMER1 = 4'h3,
    SRC_UART0 = 4'h4,
    SRC_TIMER2 = 4'h5,
    SRC_SPI = 4'h6,
    SRC_I2C = 4'h7,
    SRC_ADC = 4'h8,
    SRC_COUNTER_ARRAY = 4'h9,
    SRC_UART1 = 4'hA
  } source_type;

  // Spreads the bits of a main and an extra register over the source vector.
  function automatic logic [SRC_COUNT-1:0] gather_sources(input logic [7:0] mainByte,
                                                          input logic [7:0] extraByte);
    logic [SRC_COUNT-1:0] v;
    v = '0;
    v[SRC_EXT0] = mainByte[BIT_EXT0];
    v[SRC_TIMER0] = mainByte[BIT_TIMER0];
    v[SRC_EXT1] = mainByte[BIT_EXT1];
    v[SRC_TIMER1] = mainByte[BIT_TIMER1];
    v[SRC_UART0] = mainByte[BIT_UART0];
    v[SRC_TIMER2] = mainByte[BIT_TIMER2];
    v[SRC_SPI] = extraByte[BIT_SPI];
    v[SRC_I2C] = extraByte[BIT_I2C];
    v[SRC_ADC] = extraByte[BIT_ADC];
    v[SRC_COUNTER_ARRAY] = extraByte[BIT_COUNTER_ARRAY];
    v[SRC_UART1] = extraByte[BIT_UART1];
    return v;
  endfunction

endpackage
